// file: gmtx_pkg.sv
/*
 * Shared constants and types of the gigabit transmit path: register map,
 * field positions, frame timing counts and the carrier structs.
 * Assumes one transmit clock that is also the register bus clock.
 */
package gmtx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses) and fields.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_STATS = 12'h008;
    localparam logic [11:0] OFS_FRAMES = 12'h00c;

    localparam int CTRL_EN = 0;
    localparam int CTRL_FCS = 1;
    localparam int CTRL_JUMBO = 2;
    localparam int CTRL_IFG = 3;
    localparam logic [3:0] CTRL_RST = 4'h3;

    localparam int STS_BUSY = 0;
    localparam int STS_CAP = 1;
    localparam int STS_EMPTY = 2;
    localparam int STS_GAP_LSB = 8;

    // Statistics word fields; the frame length sits in bits 15:0.
    localparam int ST_GOOD = 16;
    localparam int ST_UNDR = 17;
    localparam int ST_PAD = 18;
    localparam int ST_FCS = 19;
    localparam int ST_OVR = 20;

    ////////////////////////////////////////////////////////////////////////
    // Frame format, counted in bytes on the byte-wide PHY side.
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] SFD_BYTE = 8'hd5;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    localparam logic [2:0] PRE_LAST = 3'h7;
    localparam logic [15:0] MIN_NOFCS = 16'h003c;
    localparam logic [15:0] MIN_WITHFCS = 16'h0040;
    localparam logic [15:0] MAX_NOFCS = 16'h05ea;
    localparam logic [15:0] MAX_WITHFCS = 16'h05ee;
    localparam logic [7:0] IFG_MIN = 8'h0c;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY = 32'hedb8_8320;

    ////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef enum logic [2:0] {
        st_idle, st_pre, st_data, st_pad, st_fcs
    } gmtx_state_t;

    typedef struct packed {
        logic last;
        logic bad;
        logic [7:0] data;
    } gmtx_word_t;

    typedef struct packed {
        logic [7:0] txd;
        logic tx_en;
        logic tx_er;
    } gmtx_gmii_t;

endpackage

// file: gmtx_fifo.sv
/*
 * Byte FIFO between the client capture stage and the transmit engine.
 * Assumes writer and reader share one clock; width and depth are
 * parameters, depth a power of two.
 */
`timescale 1ns/10ps
module gmtx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } gmtx_fptr_t;

    gmtx_fptr_t s_r, s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_wr, do_rd;

    ////////////////////////////////////////////////////////////////////////
    assign in_ready = !((s_r.wr[AW] != s_r.rd[AW]) &&
                        (s_r.wr[AW-1:0] == s_r.rd[AW-1:0]));
    assign out_valid = (s_r.wr != s_r.rd);
    assign out_data = mem[s_r.rd[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        s_nxt = s_r;
        if (do_wr) begin
            s_nxt.wr = s_r.wr + 1'b1;
        end
        if (do_rd) begin
            s_nxt.rd = s_r.rd + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge pclk) begin
        if (do_wr) begin
            mem[s_r.wr[AW-1:0]] <= in_data;
        end
    end

endmodule // gmtx_fifo

// file: gmtx_top.sv
/*
 * Transmit engine of a full-duplex gigabit MAC: client byte capture,
 * preamble, padding, check sequence, interframe gap, statistics and an
 * APB register slave.
 * Assumes the client logic runs on pclk and keeps the byte handshake.
 */
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module gmtx_top
    import gmtx_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] client_data,
    input wire logic client_valid,
    input wire logic client_underrun,
    input wire logic [7:0] client_ifg_delay,
    output logic client_ack,
    output logic [31:0] stats_vector,
    output logic stats_valid,
    output logic [7:0] gmii_txd,
    output logic gmii_tx_en,
    output logic gmii_tx_er
);

    typedef struct packed {
        gmtx_state_t state;
        logic [2:0] pre_idx;
        logic [1:0] fcs_idx;
        logic [15:0] cnt;
        logic [31:0] crc;
        logic [7:0] gap_cnt;
        logic [7:0] gap_len;
        logic hold_v;
        gmtx_word_t hold;
        logic bad;
        logic undr;
        logic ovr;
        logic pad;
        logic fcs_on;
        gmtx_gmii_t gmii;
        logic [31:0] stats;
        logic stats_v;
        logic [31:0] frames;
        logic [3:0] ctrl;
        logic [31:0] prdata;
    } gmtx_core_t;

    gmtx_core_t s_r, s_nxt;
    gmtx_word_t fifo_wdata, fifo_rdata;
    logic fifo_in_ready, fifo_out_valid, fifo_ren;
    logic gap_done, send, tail, fin;
    logic [7:0] byte_out;
    logic [15:0] min_len, max_len;
    logic [3:0] wsel, rsel;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [3:0] reg_sel(input logic [11:0] a);
        reg_sel = {a == OFS_FRAMES, a == OFS_STATS, a == OFS_STATUS,
                   a == OFS_CTRL};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Byte FIFO between client capture and the engine.
    gmtx_fifo #(
        .WIDTH($bits(gmtx_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(s_r.hold_v),
        .in_ready(fifo_in_ready),
        .in_data(fifo_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_ren),
        .out_data(fifo_rdata)
    );

    // A byte is written one cycle late so that its last flag is known.
    always_comb begin
        fifo_wdata = s_r.hold;
        fifo_wdata.last = !client_valid;
        fifo_wdata.bad = s_r.hold.bad | client_underrun;
    end

    // The gap target already holds at least the standard minimum.
    assign gap_done = s_r.gap_cnt >= (s_r.gap_len - 8'h01);
    // Only an idle engine with an empty FIFO takes a new first byte.
    assign client_ack = s_r.ctrl[CTRL_EN] && client_valid && gap_done &&
                        (s_r.state == st_idle) && !s_r.hold_v &&
                        !fifo_out_valid && fifo_in_ready;
    assign min_len = s_r.fcs_on ? MIN_NOFCS : MIN_WITHFCS;
    assign max_len = s_r.fcs_on ? MAX_NOFCS : MAX_WITHFCS;
    assign wsel = reg_sel(paddr);
    assign rsel = reg_sel(paddr);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        s_nxt = s_r;
        s_nxt.stats_v = 1'b0;
        s_nxt.gmii = '0;
        fifo_ren = 1'b0;
        send = 1'b0;
        tail = 1'b0;
        fin = 1'b0;
        byte_out = PAD_BYTE;

        // Capture stage: one byte per cycle until valid drops.
        if (client_ack) begin
            s_nxt.hold_v = 1'b1;
            s_nxt.hold = '{last: 1'b0, bad: client_underrun,
                           data: client_data};
        end else if (s_r.hold_v) begin
            if (!fifo_in_ready) begin
                s_nxt.bad = 1'b1;
            end
            if (client_valid) begin
                s_nxt.hold = '{last: 1'b0, bad: client_underrun,
                               data: client_data};
            end else begin
                s_nxt.hold_v = 1'b0;
            end
        end

        unique case (s_r.state)
            st_idle: begin
                if (s_r.gap_cnt != 8'hff) begin
                    s_nxt.gap_cnt = s_r.gap_cnt + 8'h01;
                end
                if (client_ack) begin
                    s_nxt.state = st_pre;
                    s_nxt.pre_idx = '0;
                    s_nxt.cnt = '0;
                    s_nxt.crc = CRC_INIT;
                    s_nxt.bad = client_underrun;
                    s_nxt.undr = client_underrun;
                    s_nxt.ovr = 1'b0;
                    s_nxt.pad = 1'b0;
                    s_nxt.fcs_on = s_r.ctrl[CTRL_FCS];
                end
            end
            st_pre: begin
                s_nxt.gmii.txd = (s_r.pre_idx == PRE_LAST) ? SFD_BYTE :
                                 PRE_BYTE;
                s_nxt.gmii.tx_en = 1'b1;
                s_nxt.gmii.tx_er = s_r.bad;
                s_nxt.pre_idx = s_r.pre_idx + 3'h1;
                if (s_r.pre_idx == PRE_LAST) begin
                    s_nxt.state = st_data;
                end
            end
            st_data: begin
                fifo_ren = 1'b1;
                send = 1'b1;
                if (fifo_out_valid) begin
                    byte_out = fifo_rdata.data;
                    s_nxt.bad = s_nxt.bad | fifo_rdata.bad;
                    s_nxt.undr = s_r.undr | fifo_rdata.bad;
                    tail = fifo_rdata.last;
                end else begin
                    // Starved mid-frame: send a corrupted filler byte.
                    s_nxt.bad = 1'b1;
                    tail = !s_r.hold_v;
                end
            end
            st_pad: begin
                send = 1'b1;
                tail = 1'b1;
                s_nxt.pad = 1'b1;
            end
            st_fcs: begin
                send = 1'b1;
                byte_out = ~s_r.crc[{s_r.fcs_idx, 3'b000} +: 8];
                s_nxt.fcs_idx = s_r.fcs_idx + 2'h1;
                fin = (s_r.fcs_idx == 2'h3);
            end
        endcase

        if (send) begin
            if (s_r.cnt != 16'hffff) begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
            end
            if (s_r.state != st_fcs) begin
                s_nxt.crc = crc_byte(s_r.crc, byte_out);
            end
            if (!s_r.ctrl[CTRL_JUMBO] && s_nxt.cnt > max_len) begin
                s_nxt.ovr = 1'b1;
            end
            s_nxt.gmii.txd = byte_out;
            s_nxt.gmii.tx_en = 1'b1;
            s_nxt.gmii.tx_er = s_nxt.bad | s_nxt.ovr;
        end

        if (tail) begin
            if (s_nxt.cnt < min_len) begin
                s_nxt.state = st_pad;
            end else if (s_r.fcs_on) begin
                s_nxt.state = st_fcs;
                s_nxt.fcs_idx = '0;
            end else begin
                fin = 1'b1;
            end
        end

        if (fin) begin
            s_nxt.state = st_idle;
            s_nxt.gap_cnt = '0;
            s_nxt.gap_len = (s_r.ctrl[CTRL_IFG] &&
                             client_ifg_delay > IFG_MIN) ?
                            client_ifg_delay : IFG_MIN;
            s_nxt.stats = '0;
            s_nxt.stats[15:0] = s_nxt.cnt;
            s_nxt.stats[ST_GOOD] = !(s_nxt.bad | s_nxt.ovr);
            s_nxt.stats[ST_UNDR] = s_nxt.undr;
            s_nxt.stats[ST_PAD] = s_nxt.pad;
            s_nxt.stats[ST_FCS] = s_r.fcs_on;
            s_nxt.stats[ST_OVR] = s_nxt.ovr;
            s_nxt.stats_v = 1'b1;
            s_nxt.frames = s_r.frames + 32'h0000_0001;
        end

        // APB: read data is latched in the setup phase.
        if (psel && !penable) begin
            s_nxt.prdata = '0;
            if (rsel[0]) begin
                s_nxt.prdata[3:0] = s_r.ctrl;
            end
            if (rsel[1]) begin
                s_nxt.prdata[STS_BUSY] = (s_r.state != st_idle);
                s_nxt.prdata[STS_CAP] = s_r.hold_v;
                s_nxt.prdata[STS_EMPTY] = !fifo_out_valid;
                s_nxt.prdata[STS_GAP_LSB +: 8] = s_r.gap_len;
            end
            if (rsel[2]) begin
                s_nxt.prdata = s_r.stats;
            end
            if (rsel[3]) begin
                s_nxt.prdata = s_r.frames;
            end
        end
        if (psel && penable && pwrite && wsel[0] && pstrb[0]) begin
            s_nxt.ctrl = pwdata[3:0];
        end
    end

    // One transmit clock drives everything; no duplex or speed state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.gap_cnt <= 8'hff;
            s_r.gap_len <= IFG_MIN;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. The PHY side is plain byte-wide; any DDR shim sits outside.
    assign gmii_txd = s_r.gmii.txd;
    assign gmii_tx_en = s_r.gmii.tx_en;
    assign gmii_tx_er = s_r.gmii.tx_er;
    assign stats_vector = s_r.stats;
    assign stats_valid = s_r.stats_v;
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable &&
                     ((rsel == 4'h0) || (pwrite && !wsel[0]));

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [7:0] idle_run;
    logic [15:0] wire_len;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_run <= 8'hff;
            wire_len <= '0;
        end else begin
            if (gmii_tx_en) begin
                idle_run <= '0;
            end else if (idle_run != 8'hff) begin
                idle_run <= idle_run + 8'h01;
            end
            wire_len <= gmii_tx_en ? wire_len + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_pre_start: assert property ($rose(gmii_tx_en) |->
        gmii_txd == PRE_BYTE ##7 gmii_txd == SFD_BYTE)
        else $error("preamble or delimiter missing");
    a_txen_hold: assert property ($rose(gmii_tx_en) |->
        gmii_tx_en [*8] ##1 gmii_tx_en)
        else $error("transmit enable dropped early");
    a_min_frame: assert property ($fell(gmii_tx_en) |->
        wire_len >= 16'h0048)
        else $error("frame shorter than minimum");
    // The idle count already holds the whole gap in the first busy cycle.
    a_ifg_min: assert property ($rose(gmii_tx_en) |->
        idle_run >= IFG_MIN)
        else $error("interframe gap too short");
    a_ifg_adjust: assert property ($rose(gmii_tx_en) |->
        idle_run >= s_r.gap_len)
        else $error("adjusted gap not honoured");
    a_ack_cause: assert property (client_ack |=>
        (s_r.hold_v && s_r.hold.data == $past(client_data)))
        else $error("acknowledged byte not captured");
    a_underrun_err: assert property ((client_underrun && s_r.hold_v) |->
        ##[1:30] gmii_tx_er)
        else $error("underrun did not corrupt frame");
    a_stats_end: assert property (stats_valid |->
        gmii_tx_en ##1 !gmii_tx_en)
        else $error("statistics pulse not at frame end");
    a_stats_len: assert property (stats_valid |->
        stats_vector[15:0] == wire_len - 16'd7)
        else $error("statistics length wrong");
    a_fcs_len: assert property ((stats_valid && stats_vector[ST_FCS]) |->
        stats_vector[15:0] >= MIN_WITHFCS)
        else $error("check sequence frame too short");

endmodule // gmtx_top

// file: gmtx_client.sv
/*
 * Client frame source for the transmit path: presents frame bytes on the
 * byte handshake, byte i of a frame being base plus i.
 * Assumes it shares pclk with the engine and that go is pulsed while idle.
 */
`timescale 1ns/10ps
module gmtx_client (
    input wire logic pclk,
    input wire logic go,
    input wire logic [15:0] len,
    input wire logic [7:0] base,
    input wire logic [15:0] undr_at,
    input wire logic client_ack,
    output logic [7:0] client_data,
    output logic client_valid,
    output logic client_underrun
);
    logic [15:0] idx;
    logic acked;

    initial begin
        client_data = 8'h00;
        client_valid = 1'b0;
        client_underrun = 1'b0;
        idx = 16'h0000;
        acked = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        client_underrun <= 1'b0;
        if (!client_valid) begin
            // Idle data toggles so a stale byte is never taken as valid.
            client_data <= ~client_data;
            acked <= 1'b0;
            if (go) begin
                client_valid <= 1'b1;
                client_data <= base;
                idx <= 16'h0001;
            end
        end else if (acked || client_ack) begin
            acked <= 1'b1;
            if (idx == len) begin
                client_valid <= 1'b0;
                client_data <= ~client_data;
            end else begin
                client_data <= base + idx[7:0];
                client_underrun <= (idx == undr_at);
                idx <= idx + 16'h0001;
            end
        end
    end
endmodule // gmtx_client

// file: tb.sv
/*
 * Self-checking bench of the transmit path: APB register access, frames
 * from the client model checked byte by byte against a queue model, gap,
 * statistics, underrun, and a jumbo frame streamed through the byte FIFO.
 * Assumes a 50 MHz pclk and the zero-wait APB slave of the design.
 */
`timescale 1ns/10ps
module tb;
    import gmtx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, stats_vector, st_got, rd;
    logic [3:0] pstrb;
    logic [7:0] client_data, client_ifg_delay, gmii_txd, base;
    logic client_valid, client_underrun, client_ack, stats_valid;
    logic gmii_tx_en, gmii_tx_er, go, done, er_seen, was_en, err;
    logic [15:0] len, undr_at;
    logic [7:0] exp_q[$], got_q[$];
    int fail_count, samples_checked, gap, gap_min, nfr;
    integer seed;

    gmtx_top #(.FIFO_DEPTH(16)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .client_data(client_data),
        .client_valid(client_valid), .client_underrun(client_underrun),
        .client_ifg_delay(client_ifg_delay), .client_ack(client_ack),
        .stats_vector(stats_vector), .stats_valid(stats_valid),
        .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
        .gmii_tx_er(gmii_tx_er));
    gmtx_client partner (.pclk(pclk), .go(go), .len(len), .base(base),
        .undr_at(undr_at), .client_ack(client_ack),
        .client_data(client_data), .client_valid(client_valid),
        .client_underrun(client_underrun));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 1, 0);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] crc_b(logic [31:0] c, logic [7:0] d);
        c = c ^ {24'h00_0000, d};
        for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // Builds the expected line bytes and statistics, then runs one frame.
    task automatic frame(input int n, input logic fcs, input int ua);
        int tgt, k;
        logic [31:0] c, es;
        tgt = fcs ? 60 : 64;
        exp_q = {};
        got_q = {};
        for (k = 0; k < 7; k++) exp_q.push_back(PRE_BYTE);
        exp_q.push_back(SFD_BYTE);
        c = CRC_INIT;
        for (k = 0; k < (n > tgt ? n : tgt); k++) begin
            exp_q.push_back(k < n ? base + k[7:0] : PAD_BYTE);
            c = crc_b(c, exp_q[k + 8]);
        end
        c = ~c;
        for (k = 0; k < 4 && fcs; k++) exp_q.push_back(c[8*k +: 8]);
        es = exp_q.size() - 8;
        es[ST_GOOD] = 1'b1;
        es[ST_PAD] = n < tgt;
        es[ST_FCS] = fcs;
        len <= n[15:0];
        undr_at <= ua[15:0];
        er_seen = 1'b0;
        done <= 1'b0;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 4000) begin
            chk("frame_done", 1, 0);
            wrap_up();
        end
        if (ua != 0) begin
            chk("tx_er", 1, er_seen);
            chk("st_undr", 1, st_got[ST_UNDR]);
            chk("st_good", 0, st_got[ST_GOOD]);
        end else begin
            chk("nbytes", exp_q.size(), got_q.size());
            for (k = 0; k < exp_q.size() && k < got_q.size(); k++) begin
                chk("txd", exp_q[k], got_q[k]);
            end
            chk("stats", es, st_got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (gmii_tx_en === 1'b1) begin
            if (!was_en && nfr > 0) begin
                chk("gap_ok", 1, gap >= gap_min);
            end
            got_q.push_back(gmii_txd);
            if (gmii_tx_er === 1'b1) er_seen = 1'b1;
            gap = 0;
        end else if (gap < 100000) begin
            gap++;
        end
        was_en = (gmii_tx_en === 1'b1);
        if (stats_valid === 1'b1) begin
            st_got <= stats_vector;
            done <= 1'b1;
            nfr++;
        end
    end

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, go, done} = '0;
        {paddr, pwdata, pstrb, len, undr_at} = '0;
        base = 8'h00;
        client_ifg_delay = 8'h00;
        {fail_count, samples_checked, nfr} = '0;
        gap = 0;
        gap_min = IFG_MIN;
        was_en = 1'b0;
        seed = 32'h1ce0_0478;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, 0);
        chk("ctrl_rst", {28'h000_0000, CTRL_RST}, rd);
        apb(1'b0, 12'h010, 0);
        chk("unmapped_err", 1, err);
        apb(1'b1, OFS_STATUS, 32'hffff_ffff);
        chk("ro_err", 1, err);
        apb(1'b0, OFS_STATUS, 0);
        chk("status_idle", 32'h0000_0004, rd & 32'h0000_0007);
        // The frame task builds its expectation from base at once.
        base = 8'h5a;
        frame(1, 1'b1, 0);
        for (int i = 0; i < 4; i++) begin
            base = 8'($random(seed));
            frame(60 + ($random(seed) & 63), 1'b1, 0);
        end
        client_ifg_delay <= 8'h14;
        apb(1'b1, OFS_CTRL, 32'h0000_000b);
        frame(70, 1'b1, 0);
        // The adjusted gap is latched at the end of the frame above.
        gap_min = 20;
        frame(59, 1'b1, 0);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        gap_min = IFG_MIN;
        frame(10, 1'b0, 0);
        frame(68, 1'b0, 0);
        apb(1'b0, OFS_FRAMES, 0);
        chk("frames", nfr, rd);
        apb(1'b0, OFS_STATS, 0);
        chk("stats_reg", st_got, rd);
        frame(30, 1'b1, 5);
        apb(1'b1, OFS_CTRL, 32'h0000_0007);
        chk("ctrl_wr_err", 0, err);
        frame(1600, 1'b1, 0);
        apb(1'b0, OFS_STATUS, 0);
        chk("fifo_empty", 32'h0000_0004, rd & 32'h0000_0007);
        wrap_up();
    end
endmodule // tb
